//--- common/pmc_pkg.sv
// package for the power mode controller: modes, control bit groups, timing counts
// assumes a single 200 MHz system clock
package pmc_pkg;

	localparam int unsigned CLK_PERIOD_NS = 5;

	// settle wait in system clock cycles for each settle_wait_sel code
	localparam int unsigned SETTLE_W      = 18;
	localparam logic [17:0] SETTLE_0      = 18'h02000;
	localparam logic [17:0] SETTLE_1      = 18'h04000;
	localparam logic [17:0] SETTLE_2      = 18'h08000;
	localparam logic [17:0] SETTLE_3      = 18'h10000;
	localparam logic [17:0] SETTLE_4      = 18'h3ffff;
	localparam logic [17:0] SETTLE_5      = 18'h00002;
	localparam logic [17:0] SETTLE_6      = 18'h00008;
	localparam logic [17:0] SETTLE_7      = 18'h00010;

	// interrupt synchroniser depth, i.e. at most 2 system clock periods of delay
	localparam int unsigned IRQ_SYNC_DEPTH = 2;

	// watch clock divider: sub clock runs at watch/2, /4, /8
	localparam int unsigned WDIV_W        = 3;
	localparam logic [1:0]  SUB_DIV2      = 2'h0;
	localparam logic [1:0]  SUB_DIV4      = 2'h1;
	localparam logic [1:0]  SUB_DIV8_A    = 2'h2;
	localparam logic [1:0]  SUB_DIV8_B    = 2'h3;

	// medium speed peripheral clock divider select width
	localparam int unsigned MDIV_W        = 2;

	typedef enum logic [3:0]
	{
		PMC_ACTIVE_HI,
		PMC_ACTIVE_MED,
		PMC_SLEEP_HI,
		PMC_SLEEP_MED,
		PMC_STANDBY,
		PMC_WATCH,
		PMC_SUBACTIVE,
		PMC_SUBSLEEP,
		PMC_SETTLE
	} pmc_mode_e;

	typedef struct packed
	{
		logic       standby_select;
		logic       low_speed_select;
		logic       medium_speed_select;
		logic       direct_transition_enable;
		logic       timekeeping_select;
		logic [2:0] settle_wait_sel;
		logic [1:0] medium_divider;
		logic [1:0] sub_speed;
	} pmc_cfg_s;

	typedef struct packed
	{
		logic       osc_run;
		logic       sub_clk_en;
		logic       cpu_run;
		logic       periph_clk_en;
		logic       timekeep_en;
		logic       adc_pwm_en;
		logic       io_hiz;
		logic       io_hold;
	} pmc_gate_s;

endpackage

//--- core/pmc_mode_ctrl.sv
// power mode controller: halt sequencing, wake on interrupt, clock gating
// assumes halt request from the cpu core on CLK_SYS; interrupt lines may be asynchronous
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl
(
	input  wire logic                         CLK_SYS,
	input  wire logic                         RESET_N,
	input  wire logic                         CE,
	input  wire logic                         RESET_PIN_N,
	input  wire logic                         HALT_REQ,
	input  wire pmc_pkg::pmc_cfg_s            CFG,
	input  wire logic                         CPU_INT_MASK,
	input  wire logic [7:0]                   IRQ_LINES,
	input  wire logic [7:0]                   IRQ_ENABLE,
	input  wire logic                         DIRECT_INT_ENABLE,
	output var  pmc_pkg::pmc_mode_e           MODE,
	output var  pmc_pkg::pmc_gate_s           GATES,
	output var  logic                         EXC_START,
	output var  logic                         DIRECT_EXC,
	output var  logic                         CPU_RESET,
	output var  logic [1:0]                   MEDIUM_DIV,
	output var  logic [1:0]                   SUB_SPEED
);
	pmc_pkg::pmc_mode_e mode_r;
	pmc_pkg::pmc_mode_e mode_nxt;
	logic [7:0] irq_s1_r;
	logic [7:0] irq_s2_r;
	logic       rpin_s1_r;
	logic       rpin_s2_r;
	logic       wake;
	logic       settle_start;
	logic       settle_done;
	logic       settle_direct_r;
	logic       exc_nxt;
	logic       dexc_nxt;

	// two-flop synchronisers for asynchronous pins
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			irq_s1_r  <= '0;
			irq_s2_r  <= '0;
			rpin_s1_r <= 1'b1;
			rpin_s2_r <= 1'b1;
		end
		else if (CE)
		begin
			irq_s1_r  <= IRQ_LINES;
			irq_s2_r  <= irq_s1_r;
			rpin_s1_r <= RESET_PIN_N;
			rpin_s2_r <= rpin_s1_r;
		end
	end

	assign wake = !CPU_INT_MASK && |(irq_s2_r & IRQ_ENABLE);

	function automatic logic is_active(input pmc_pkg::pmc_mode_e m);
		is_active = (m == pmc_pkg::PMC_ACTIVE_HI) || (m == pmc_pkg::PMC_ACTIVE_MED);
	endfunction

	function automatic pmc_pkg::pmc_mode_e active_of(input logic med);
		active_of = med ? pmc_pkg::PMC_ACTIVE_MED : pmc_pkg::PMC_ACTIVE_HI;
	endfunction

	// next mode; settle_start pulses when the oscillator is restarted
	always_comb
	begin
		mode_nxt     = mode_r;
		settle_start = 1'b0;
		exc_nxt      = 1'b0;
		dexc_nxt     = 1'b0;
		unique case (mode_r)
			pmc_pkg::PMC_ACTIVE_HI,
			pmc_pkg::PMC_ACTIVE_MED:
			begin
				if (HALT_REQ)
				begin
					if (CFG.standby_select && !CFG.low_speed_select && !CFG.timekeeping_select)
						mode_nxt = pmc_pkg::PMC_STANDBY;
					else if (CFG.standby_select && CFG.timekeeping_select)
					begin
						if (CFG.low_speed_select && CFG.direct_transition_enable
							&& DIRECT_INT_ENABLE && !CPU_INT_MASK)
						begin
							mode_nxt = pmc_pkg::PMC_SUBACTIVE;
							dexc_nxt = 1'b1;
						end
						else
							mode_nxt = pmc_pkg::PMC_WATCH;
					end
					else if (!CFG.standby_select && !CFG.low_speed_select
						&& CFG.direct_transition_enable && DIRECT_INT_ENABLE && !CPU_INT_MASK)
					begin
						mode_nxt = active_of(CFG.medium_speed_select);
						dexc_nxt = 1'b1;
					end
					else
						mode_nxt = (mode_r == pmc_pkg::PMC_ACTIVE_MED) ?
							pmc_pkg::PMC_SLEEP_MED : pmc_pkg::PMC_SLEEP_HI;
				end
			end
			pmc_pkg::PMC_SLEEP_HI:
			begin
				if (wake)
				begin
					mode_nxt = pmc_pkg::PMC_ACTIVE_HI;
					exc_nxt  = 1'b1;
				end
			end
			pmc_pkg::PMC_SLEEP_MED:
			begin
				if (wake)
				begin
					mode_nxt = pmc_pkg::PMC_ACTIVE_MED;
					exc_nxt  = 1'b1;
				end
			end
			pmc_pkg::PMC_STANDBY:
			begin
				if (wake)
				begin
					mode_nxt     = pmc_pkg::PMC_SETTLE;
					settle_start = 1'b1;
				end
			end
			pmc_pkg::PMC_WATCH:
			begin
				if (wake)
				begin
					if (CFG.low_speed_select)
					begin
						mode_nxt = pmc_pkg::PMC_SUBACTIVE;
						exc_nxt  = 1'b1;
					end
					else
					begin
						mode_nxt     = pmc_pkg::PMC_SETTLE;
						settle_start = 1'b1;
					end
				end
			end
			pmc_pkg::PMC_SUBACTIVE:
			begin
				if (HALT_REQ)
				begin
					if (CFG.standby_select && !CFG.low_speed_select && CFG.direct_transition_enable
						&& CFG.timekeeping_select && DIRECT_INT_ENABLE && !CPU_INT_MASK)
					begin
						mode_nxt     = pmc_pkg::PMC_SETTLE;
						settle_start = 1'b1;
					end
					else if (CFG.standby_select && CFG.timekeeping_select)
						mode_nxt = pmc_pkg::PMC_WATCH;
					else
						mode_nxt = pmc_pkg::PMC_SUBSLEEP;
				end
			end
			pmc_pkg::PMC_SUBSLEEP:
			begin
				if (wake)
				begin
					mode_nxt = pmc_pkg::PMC_SUBACTIVE;
					exc_nxt  = 1'b1;
				end
			end
			pmc_pkg::PMC_SETTLE:
			begin
				if (settle_done)
				begin
					mode_nxt = active_of(CFG.medium_speed_select);
					exc_nxt  = !settle_direct_r;
					dexc_nxt = settle_direct_r;
				end
			end
			default:
				mode_nxt = pmc_pkg::PMC_ACTIVE_HI;
		endcase
	end

	pmc_settle_timer u_settle
	(
		.clk   (CLK_SYS),
		.rst_n (RESET_N),
		.ce    (CE),
		.start (settle_start),
		.sel   (CFG.settle_wait_sel),
		.done  (settle_done)
	);

	// mode register; reset pin overrides any mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			mode_r <= pmc_pkg::PMC_ACTIVE_HI;
		else if (CE)
		begin
			if (!rpin_s2_r)
				mode_r <= pmc_pkg::PMC_ACTIVE_HI;
			else
				mode_r <= mode_nxt;
		end
	end

	// remembers whether a settle wait came from a direct transition
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			settle_direct_r <= 1'b0;
		end
		else if (CE && settle_start)
		begin
			settle_direct_r <= (mode_r == pmc_pkg::PMC_SUBACTIVE);
		end
	end

	// outputs
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			MODE       <= pmc_pkg::PMC_ACTIVE_HI;
			EXC_START  <= 1'b0;
			DIRECT_EXC <= 1'b0;
			CPU_RESET  <= 1'b1;
		end
		else if (CE)
		begin
			MODE       <= rpin_s2_r ? mode_nxt : pmc_pkg::PMC_ACTIVE_HI;
			EXC_START  <= rpin_s2_r && exc_nxt;
			DIRECT_EXC <= rpin_s2_r && dexc_nxt;
			CPU_RESET  <= !rpin_s2_r;
		end
	end

	// clock gating per mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			GATES <= '{osc_run: 1'b1, sub_clk_en: 1'b0, cpu_run: 1'b1, periph_clk_en: 1'b1,
				timekeep_en: 1'b1, adc_pwm_en: 1'b1, io_hiz: 1'b0, io_hold: 1'b0};
		else if (CE)
		begin
			unique case (rpin_s2_r ? mode_nxt : pmc_pkg::PMC_ACTIVE_HI)
				pmc_pkg::PMC_ACTIVE_HI,
				pmc_pkg::PMC_ACTIVE_MED:
					GATES <= '{osc_run: 1'b1, sub_clk_en: 1'b0, cpu_run: 1'b1, periph_clk_en: 1'b1,
						timekeep_en: 1'b1, adc_pwm_en: 1'b1, io_hiz: 1'b0, io_hold: 1'b0};
				pmc_pkg::PMC_SLEEP_HI,
				pmc_pkg::PMC_SLEEP_MED:
					GATES <= '{osc_run: 1'b1, sub_clk_en: 1'b0, cpu_run: 1'b0, periph_clk_en: 1'b1,
						timekeep_en: 1'b1, adc_pwm_en: 1'b1, io_hiz: 1'b0, io_hold: 1'b0};
				pmc_pkg::PMC_STANDBY:
					GATES <= '{osc_run: 1'b0, sub_clk_en: 1'b0, cpu_run: 1'b0, periph_clk_en: 1'b0,
						timekeep_en: 1'b0, adc_pwm_en: 1'b0, io_hiz: 1'b1, io_hold: 1'b0};
				pmc_pkg::PMC_SETTLE:
					GATES <= '{osc_run: 1'b1, sub_clk_en: 1'b0, cpu_run: 1'b0, periph_clk_en: 1'b0,
						timekeep_en: 1'b1, adc_pwm_en: 1'b0, io_hiz: 1'b0, io_hold: 1'b1};
				pmc_pkg::PMC_WATCH:
					GATES <= '{osc_run: 1'b0, sub_clk_en: 1'b0, cpu_run: 1'b0, periph_clk_en: 1'b0,
						timekeep_en: 1'b1, adc_pwm_en: 1'b0, io_hiz: 1'b0, io_hold: 1'b1};
				pmc_pkg::PMC_SUBACTIVE:
					GATES <= '{osc_run: 1'b0, sub_clk_en: 1'b1, cpu_run: 1'b1, periph_clk_en: 1'b1,
						timekeep_en: 1'b1, adc_pwm_en: 1'b0, io_hiz: 1'b0, io_hold: 1'b0};
				pmc_pkg::PMC_SUBSLEEP:
					GATES <= '{osc_run: 1'b0, sub_clk_en: 1'b1, cpu_run: 1'b0, periph_clk_en: 1'b1,
						timekeep_en: 1'b1, adc_pwm_en: 1'b0, io_hiz: 1'b0, io_hold: 1'b1};
				default:
					GATES <= '0;
			endcase
		end
	end

	// divider selects: medium divider follows field, sub speed latched at halt
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			MEDIUM_DIV <= '0;
			SUB_SPEED  <= pmc_pkg::SUB_DIV8_A;
		end
		else if (CE)
		begin
			MEDIUM_DIV <= CFG.medium_divider;
			if (HALT_REQ && rpin_s2_r)
				SUB_SPEED <= CFG.sub_speed;
		end
	end

	chk_wake_masked: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && CPU_INT_MASK && mode_r inside {pmc_pkg::PMC_SLEEP_HI, pmc_pkg::PMC_SLEEP_MED,
		pmc_pkg::PMC_STANDBY, pmc_pkg::PMC_WATCH, pmc_pkg::PMC_SUBSLEEP}) |=> mode_r == $past(mode_r))
		else $error("masked interrupt woke light halt");
	chk_sleep_return: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && wake && mode_r == pmc_pkg::PMC_SLEEP_MED)
		|=> mode_r == pmc_pkg::PMC_ACTIVE_MED && EXC_START)
		else $error("light halt did not return to medium speed");
	chk_reset_pin: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && !rpin_s2_r) |=> CPU_RESET && mode_r == pmc_pkg::PMC_ACTIVE_HI)
		else $error("reset pin did not reset cpu");
	chk_standby_hiz: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(MODE == pmc_pkg::PMC_STANDBY) |-> GATES.io_hiz && !GATES.osc_run && !GATES.cpu_run)
		else $error("standby gating wrong");
	chk_standby_entry: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && is_active(mode_r) && HALT_REQ && CFG.standby_select
		&& !CFG.low_speed_select && !CFG.timekeeping_select) |=> mode_r == pmc_pkg::PMC_STANDBY)
		else $error("standby not entered");
	chk_settle_start: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && wake && mode_r == pmc_pkg::PMC_STANDBY)
		|=> mode_r == pmc_pkg::PMC_SETTLE && GATES.osc_run) else $error("standby wake did not restart oscillator");
	chk_settle_exit: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && mode_r == pmc_pkg::PMC_SETTLE && settle_done)
		|=> is_active(mode_r) && (mode_r == pmc_pkg::PMC_ACTIVE_MED) == $past(CFG.medium_speed_select))
		else $error("settle exit speed wrong");
	chk_subsleep_back: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && rpin_s2_r && wake && mode_r == pmc_pkg::PMC_SUBSLEEP) |=> mode_r == pmc_pkg::PMC_SUBACTIVE)
		else $error("subsleep did not return to subactive");
	chk_sub_speed_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(CE && !HALT_REQ) |=> $stable(SUB_SPEED))
		else $error("sub speed changed without halt");
	cov_standby_wake: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		mode_r == pmc_pkg::PMC_SETTLE && settle_done);
	cov_direct_sub: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		is_active(mode_r) ##1 mode_r == pmc_pkg::PMC_SUBACTIVE);
	cov_sleep_wake: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		mode_r == pmc_pkg::PMC_SLEEP_HI ##1 EXC_START);
endmodule // pmc_mode_ctrl
`default_nettype wire

//--- core/pmc_settle_timer.sv
// settle wait counter for oscillator restart
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module pmc_settle_timer
(
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire logic                         start,
	input  wire logic [2:0]                   sel,
	output var  logic                         done
);
	logic [pmc_pkg::SETTLE_W-1:0] cnt_r;
	logic                         busy_r;

	function automatic logic [pmc_pkg::SETTLE_W-1:0] settle_len(input logic [2:0] s);
		unique case (s)
			3'h0: settle_len = pmc_pkg::SETTLE_0;
			3'h1: settle_len = pmc_pkg::SETTLE_1;
			3'h2: settle_len = pmc_pkg::SETTLE_2;
			3'h3: settle_len = pmc_pkg::SETTLE_3;
			3'h4: settle_len = pmc_pkg::SETTLE_4;
			3'h5: settle_len = pmc_pkg::SETTLE_5;
			3'h6: settle_len = pmc_pkg::SETTLE_6;
			3'h7: settle_len = pmc_pkg::SETTLE_7;
		endcase
	endfunction

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done   <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_r  <= settle_len(sel) - 1'b1;
				busy_r <= 1'b1;
			end
			else if (busy_r)
			begin
				if (cnt_r == '0)
				begin
					busy_r <= 1'b0;
					done   <= 1'b1;
				end
				else
					cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // pmc_settle_timer
`default_nettype wire

//--- dv/pmc_cpu_model.sv
// cpu core and interrupt source model on the far side of the power mode controller
// assumes bench commands arrive on the same clock; all outputs change just after an edge
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model
#(
	parameter int HOLD = 40
)
(
	input  wire logic               clk,
	input  wire logic               halt_cmd,
	input  wire logic [7:0]         irq_cmd,
	input  wire logic               rst_cmd,
	input  wire pmc_pkg::pmc_gate_s gates,
	output var  logic               halt_req,
	output var  logic [7:0]         irq_lines,
	output var  logic               reset_pin_n
);
	logic [7:0] hold_r;

	initial
	begin
		halt_req = 1'h0;
		irq_lines = 8'h00;
		hold_r = 8'h00;
	end

	// halt instruction only while the core executes
	always @(posedge clk)
		halt_req <= halt_cmd & gates.cpu_run;

	always @(posedge clk)
		irq_lines <= irq_cmd;

	// pin held low long enough for the oscillator to settle
	always @(posedge clk)
		hold_r <= rst_cmd ? 8'(HOLD) : (hold_r != 8'h00 ? hold_r - 8'h01 : hold_r);

	assign reset_pin_n = (hold_r == 8'h00);
endmodule // pmc_cpu_model
`default_nettype wire

//--- dv/power_mode_controller_tb_top.sv
// bench for the power mode controller: mode chain, masking, reset pin, dividers
// assumes the cpu model beside it and settle code 5 for short waits
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb_top;
	localparam pmc_pkg::pmc_mode_e AHI = pmc_pkg::PMC_ACTIVE_HI, AMD = pmc_pkg::PMC_ACTIVE_MED,
		SHI = pmc_pkg::PMC_SLEEP_HI, SMD = pmc_pkg::PMC_SLEEP_MED, STB = pmc_pkg::PMC_STANDBY,
		WAT = pmc_pkg::PMC_WATCH, SUB = pmc_pkg::PMC_SUBACTIVE, SSL = pmc_pkg::PMC_SUBSLEEP,
		SET = pmc_pkg::PMC_SETTLE;

	// bits: standby, low speed, medium speed, direct, timekeeping
	typedef struct packed
	{
		logic [4:0]         bits;
		logic               dint;
		pmc_pkg::pmc_mode_e m1;
		logic               irq;
		pmc_pkg::pmc_mode_e m2;
		logic               dexc;
	} pmc_row_s;

	pmc_row_s rows [12] = '{
		'{5'h00, 1'h0, SHI, 1'h1, AHI, 1'h0},
		'{5'h10, 1'h0, STB, 1'h1, AHI, 1'h0},
		'{5'h14, 1'h0, STB, 1'h1, AMD, 1'h0},
		'{5'h04, 1'h0, SMD, 1'h1, AMD, 1'h0},
		'{5'h11, 1'h0, WAT, 1'h1, AHI, 1'h0},
		'{5'h06, 1'h1, AMD, 1'h0, AMD, 1'h1},
		'{5'h02, 1'h1, AHI, 1'h0, AHI, 1'h1},
		'{5'h02, 1'h0, SHI, 1'h1, AHI, 1'h0},
		'{5'h1b, 1'h1, SUB, 1'h0, SUB, 1'h1},
		'{5'h08, 1'h0, SSL, 1'h1, SUB, 1'h0},
		'{5'h19, 1'h0, WAT, 1'h1, SUB, 1'h0},
		'{5'h17, 1'h1, SET, 1'h0, AMD, 1'h1}
	};

	logic               clk      = 1'h0;
	logic               rst_n    = 1'h0;
	logic               halt_cmd = 1'h0;
	logic               rst_cmd  = 1'h0;
	logic [7:0]         irq_cmd  = 8'h00;
	logic               mask     = 1'h0;
	logic [7:0]         irq_en   = 8'hff;
	logic               dint     = 1'h0;
	logic               ce       = 1'h1;
	pmc_pkg::pmc_cfg_s  cfg      = '0;
	logic               halt_req;
	logic               reset_pin_n;
	logic [7:0]         irq_lines;
	pmc_pkg::pmc_mode_e mode;
	pmc_pkg::pmc_gate_s gates;
	logic               exc;
	logic               dexc;
	logic               cpu_rst;
	logic [1:0]         mdiv;
	logic [1:0]         sspd;
	int                 errors   = 0;
	int                 compares = 0;
	int                 cyc      = 0;
	int                 k;

	pmc_cpu_model cpu
	(
		.clk(clk), .halt_cmd(halt_cmd), .irq_cmd(irq_cmd), .rst_cmd(rst_cmd), .gates(gates),
		.halt_req(halt_req), .irq_lines(irq_lines), .reset_pin_n(reset_pin_n)
	);

	pmc_mode_ctrl dut
	(
		.CLK_SYS(clk), .RESET_N(rst_n), .CE(ce), .RESET_PIN_N(reset_pin_n), .HALT_REQ(halt_req),
		.CFG(cfg), .CPU_INT_MASK(mask), .IRQ_LINES(irq_lines), .IRQ_ENABLE(irq_en),
		.DIRECT_INT_ENABLE(dint), .MODE(mode), .GATES(gates), .EXC_START(exc), .DIRECT_EXC(dexc),
		.CPU_RESET(cpu_rst), .MEDIUM_DIV(mdiv), .SUB_SPEED(sspd)
	);

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			errors++;
			print_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// set the select bits, issue one halt, wait for the mode to move
	task automatic go(input logic [4:0] b);
		pmc_pkg::pmc_mode_e was;
		@(posedge clk);
		{cfg.standby_select, cfg.low_speed_select, cfg.medium_speed_select, cfg.direct_transition_enable,
			cfg.timekeeping_select} <= b;
		@(posedge clk) halt_cmd <= 1'h1;
		@(posedge clk) halt_cmd <= 1'h0;
		was = mode;
		for (k = 0; k < 50 && mode === was; k++)
			tick(1);
	endtask

	task automatic wait_exc();
		for (k = 0; k < 100 && exc !== 1'h1 && dexc !== 1'h1; k++)
			tick(1);
	endtask

	task automatic irq_off();
		@(posedge clk) irq_cmd <= 8'h00;
		tick(4);
	endtask

	// expected gate levels per mode other than SET, which is not modelled
	function automatic logic [7:0] gexp(input pmc_pkg::pmc_mode_e m);
		pmc_pkg::pmc_gate_s g;
		g.osc_run       = (m == AHI || m == AMD || m == SHI || m == SMD);
		g.sub_clk_en    = (m == SUB || m == SSL);
		g.cpu_run       = (m == AHI || m == AMD || m == SUB);
		g.periph_clk_en = (m != STB && m != WAT);
		g.timekeep_en   = (m != STB);
		g.adc_pwm_en    = g.osc_run;
		g.io_hiz        = (m == STB);
		g.io_hold       = (m == WAT || m == SSL);
		gexp = g;
	endfunction

	initial
	begin
		cfg.settle_wait_sel = 3'h5;
		repeat (2) @(posedge clk);
		tick(1);
		chk(mode, AHI);
		chk({cpu_rst, sspd}, 8'h06);
		@(posedge clk) rst_n <= 1'h1;
		tick(3);
		$display("reset test done");
		foreach (rows[i])
		begin
			@(posedge clk) dint <= rows[i].dint;
			go(rows[i].bits);
			chk(mode, rows[i].m1);
			if (rows[i].m1 != SET)
				chk(gates, gexp(rows[i].m1));
			if (rows[i].m1 == rows[i].m2)
				chk(dexc, rows[i].dexc);
			else
			begin
				if (rows[i].irq)
					@(posedge clk) irq_cmd <= 8'h01;
				wait_exc();
				if (rows[i].m1 inside {SHI, SMD, SSL})
					chk(8'(k <= 5), 8'h01);
				chk(mode, rows[i].m2);
				chk(dexc, rows[i].dexc);
				tick(1);
				chk({exc, dexc}, 8'h00);
				irq_off();
			end
			$display("row %0d done", i);
		end
		@(posedge clk) mask <= 1'h1;
		go(5'h06);
		chk(mode, SMD);
		@(posedge clk) irq_cmd <= 8'h01;
		tick(10);
		chk(mode, SMD);
		@(posedge clk) mask <= 1'h0;
		irq_en <= 8'hfe;
		tick(10);
		chk(mode, SMD);
		@(posedge clk) irq_en <= 8'hff;
		wait_exc();
		chk(mode, AMD);
		irq_off();
		$display("mask test done");
		@(posedge clk) cfg.medium_divider <= 2'h2;
		cfg.sub_speed <= 2'h3;
		tick(3);
		chk(mdiv, 8'h02);
		chk(sspd, 8'h00);
		go(5'h04);
		chk(sspd, 8'h03);
		chk(mode, SMD);
		$display("divider test done");
		@(posedge clk) rst_cmd <= 1'h1;
		@(posedge clk) rst_cmd <= 1'h0;
		for (k = 0; k < 10 && cpu_rst !== 1'h1; k++)
			tick(1);
		chk(cpu_rst, 8'h01);
		tick(1);
		chk(mode, AHI);
		tick(50);
		chk(cpu_rst, 8'h00);
		$display("reset pin test done");
		go(5'h10);
		chk(mode, STB);
		@(posedge clk) rst_cmd <= 1'h1;
		@(posedge clk) rst_cmd <= 1'h0;
		tick(60);
		chk({cpu_rst, mode}, {4'h0, AHI});
		$display("standby reset test done");
		go(5'h00);
		chk(mode, SHI);
		@(posedge clk) ce <= 1'h0;
		irq_cmd <= 8'h01;
		tick(8);
		chk(mode, SHI);
		@(posedge clk) ce <= 1'h1;
		wait_exc();
		chk(mode, AHI);
		irq_off();
		$display("clock enable test done");
		print_verdict();
	end
endmodule // power_mode_controller_tb_top
`default_nettype wire
